/* File: hw/poc_defs.vh */
// constants and behaviour summary for the port over-current and hvi check block
// Behaviour
// - route code 00 links capture to serial0
// - route code 10 links capture to serial1
// - monitor active only while its enable set
// - supply pin supervised high side, full drive
// - stop mode disables monitor and full drive
// - supply over-current forces low, sets flag
// - ground pins mirrored: sink supervised, forced off
// - analog non-direct: analog on, direct off
// - pull select one pull-up, zero pull-down
// - buffer force keeps digital buffer in analog non-direct outside stop
// - flag holds output disabled until cleared
// - flag interrupts only when enable set
// - outside stop, analog buffer off unless force and non-direct
`ifndef POC_DEFS_VH
`define POC_DEFS_VH
`define POC_ADDR_W 4
// register offsets
`define POC_OFF_DATA 4'h0
`define POC_OFF_DIR 4'h1
`define POC_OFF_ROUTE 4'h2
`define POC_OFF_OCEN 4'h3
`define POC_OFF_OCFLAG 4'h4
`define POC_OFF_OCMASK 4'h5
`define POC_OFF_HVCTL 4'h6
`define POC_OFF_HVSTAT 4'h7
`define POC_OFF_DRIVE 4'h8
// route codes
`define POC_ROUTE_SER0 2'b00
`define POC_ROUTE_SER1 2'b10
// pin positions within the protected port
`define POC_PIN_SUPPLY 2
// hv control field positions
`define POC_HV_ANALOG 0
`define POC_HV_DIRECT 1
`define POC_HV_PULL 2
`define POC_HV_FORCE 3
`define POC_HV_DIGEN 4
`endif

/* File: hw/poc_sync2.v */
// two flip-flop synchroniser, parameterised width
`timescale 1ns/1ps
`default_nettype none
module poc_sync2 #(
    parameter W = 1
) (
    input wire core_clk,
    input wire rst_n,
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;
    // first stage read only by second stage
    always @(posedge core_clk) begin
        if (!rst_n) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end
    assign sync_out = sync_reg;
endmodule
`default_nettype wire

/* File: hw/poc_top.v */
// port integration: capture routing, over-current guard, hv input check
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "poc_defs.vh"
module poc_top (
    input wire core_clk,
    input wire rst_n,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // system mode
    input wire stop_mode,
    // capture routing
    input wire serial0_receive_line,
    input wire serial1_receive_line,
    output wire capture_in3,
    // port pins, bit 2 supply switch, bits 6,5,4,0 ground switches
    input wire [7:0] port_pin_in,
    input wire [7:0] periph_out,
    input wire [7:0] periph_sel,
    output wire [7:0] port_pin_out,
    output wire [7:0] port_pin_oe,
    output wire [7:0] port_full_drive,
    // analog over-current comparators per pin
    input wire [7:0] overcurrent_det,
    output wire [7:0] overcurrent_monitor_pwr,
    // high voltage input
    input wire high_voltage_input,
    output wire hv_pullup_on,
    output wire hv_pulldown_on,
    output wire hv_analog_path_on,
    output wire hv_divider_bypass,
    output wire hv_buffer_on,
    output wire irq
);
    // protected pins: supply (2) and grounds (6,5,4,0)
    localparam [7:0] PROT_MASK = 8'h75;
    localparam [7:0] SUPPLY_MASK = 8'h04;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [7:0] port_output_latch;
    reg [7:0] port_direction_reg;
    reg [1:0] capture_route_sel;
    reg [7:0] overcurrent_monitor_en;
    reg [7:0] overcurrent_flag;
    reg [7:0] overcurrent_flag_next;
    reg [7:0] overcurrent_irq_en;
    reg [7:0] drive_full_reg;
    reg hv_analog_en;
    reg hv_direct_path_sel;
    reg hv_pull_sel;
    reg hv_buffer_force;
    reg hv_digital_en;
    wire hv_sync;
    wire [7:0] oc_sync;

    function is_addr;
        input [3:0] a;
        input [3:0] off;
        begin
            is_addr = (a == off);
        end
    endfunction

    // ------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------
    poc_sync2 #(.W(9)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({high_voltage_input, overcurrent_det}),
        .sync_out({hv_sync, oc_sync})
    );

    // ------------------------------------------------------------
    // capture routing
    // ------------------------------------------------------------
    // only code 10 selects serial one; others default to serial zero
    assign capture_in3 = (capture_route_sel == `POC_ROUTE_SER1) ? serial1_receive_line :
                         serial0_receive_line;

    // ------------------------------------------------------------
    // over-current supervision
    // ------------------------------------------------------------
    wire [7:0] pin_drive_val;
    wire [7:0] monitor_active;
    wire [7:0] sourcing;
    wire [7:0] oc_event;
    wire [7:0] inactive_level;
    genvar gi;
    // output source: peripheral or port latch
    assign pin_drive_val = (periph_sel & periph_out) | (~periph_sel & port_output_latch);
    // monitor powered only while enabled and not in stop
    assign monitor_active = overcurrent_monitor_en & PROT_MASK & {8{~stop_mode}};
    assign overcurrent_monitor_pwr = monitor_active;
    // full drive lost in stop
    assign port_full_drive = drive_full_reg & {8{~stop_mode}};
    // supply pin sources when high, ground pins sink when low
    assign inactive_level = ~SUPPLY_MASK;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_oc
            assign sourcing[gi] = port_direction_reg[gi] & (pin_drive_val[gi] != inactive_level[gi]);
            assign oc_event[gi] = monitor_active[gi] & port_full_drive[gi] & sourcing[gi] & oc_sync[gi];
            // forced to disabled level while flag set
            assign port_pin_out[gi] = overcurrent_flag[gi] ? inactive_level[gi] : pin_drive_val[gi];
        end
    endgenerate
    assign port_pin_oe = port_direction_reg;

    // flag: hardware set beats write-one clear
    always @* begin
        overcurrent_flag_next = overcurrent_flag;
        if (reg_wr && is_addr(reg_addr, `POC_OFF_OCFLAG)) begin
            overcurrent_flag_next = overcurrent_flag & ~reg_wdata;
        end
        overcurrent_flag_next = (overcurrent_flag_next | oc_event) & PROT_MASK;
    end

    assign irq = |(overcurrent_flag & overcurrent_irq_en);

    // ------------------------------------------------------------
    // high voltage input
    // ------------------------------------------------------------
    wire hv_analog_nondirect;
    assign hv_analog_nondirect = hv_analog_en & ~hv_direct_path_sel;
    assign hv_analog_path_on = hv_analog_en & ~stop_mode;
    assign hv_divider_bypass = hv_analog_en & hv_direct_path_sel;
    assign hv_pullup_on = hv_pull_sel;
    assign hv_pulldown_on = ~hv_pull_sel;
    // analog outside stop: buffer off unless forced in non-direct mode; in stop it follows the digital enable
    assign hv_buffer_on = stop_mode ? hv_digital_en :
                          (hv_analog_en ? (hv_buffer_force & hv_analog_nondirect) : hv_digital_en);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rst_n) begin
            port_output_latch <= 8'h00;
            port_direction_reg <= 8'h00;
            capture_route_sel <= 2'b00;
            overcurrent_monitor_en <= 8'h00;
            overcurrent_flag <= 8'h00;
            overcurrent_irq_en <= 8'h00;
            drive_full_reg <= 8'h00;
            hv_analog_en <= 1'b0;
            hv_direct_path_sel <= 1'b0;
            hv_pull_sel <= 1'b0;
            hv_buffer_force <= 1'b0;
            hv_digital_en <= 1'b0;
        end else begin
            overcurrent_flag <= overcurrent_flag_next;
            if (reg_wr) begin
                case (reg_addr)
                    `POC_OFF_DATA: begin
                        port_output_latch <= reg_wdata;
                    end
                    `POC_OFF_DIR: begin
                        port_direction_reg <= reg_wdata;
                    end
                    `POC_OFF_ROUTE: begin
                        capture_route_sel <= reg_wdata[1:0];
                    end
                    `POC_OFF_OCEN: begin
                        overcurrent_monitor_en <= reg_wdata & PROT_MASK;
                    end
                    `POC_OFF_OCMASK: begin
                        overcurrent_irq_en <= reg_wdata & PROT_MASK;
                    end
                    `POC_OFF_DRIVE: begin
                        drive_full_reg <= reg_wdata;
                    end
                    `POC_OFF_HVCTL: begin
                        hv_analog_en <= reg_wdata[`POC_HV_ANALOG];
                        hv_direct_path_sel <= reg_wdata[`POC_HV_DIRECT];
                        hv_pull_sel <= reg_wdata[`POC_HV_PULL];
                        hv_buffer_force <= reg_wdata[`POC_HV_FORCE];
                        hv_digital_en <= reg_wdata[`POC_HV_DIGEN];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // register reads, one cycle later
    // ------------------------------------------------------------
    wire hv_input_state;
    // input state reads zero while buffer is off
    assign hv_input_state = hv_sync & hv_buffer_on;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `POC_OFF_DATA: reg_rdata <= port_output_latch;
                `POC_OFF_DIR: reg_rdata <= port_direction_reg;
                `POC_OFF_ROUTE: reg_rdata <= {6'h00, capture_route_sel};
                `POC_OFF_OCEN: reg_rdata <= overcurrent_monitor_en;
                `POC_OFF_OCFLAG: reg_rdata <= overcurrent_flag;
                `POC_OFF_OCMASK: reg_rdata <= overcurrent_irq_en;
                `POC_OFF_HVCTL: reg_rdata <= {3'h0, hv_digital_en, hv_buffer_force, hv_pull_sel,
                                              hv_direct_path_sel, hv_analog_en};
                `POC_OFF_HVSTAT: reg_rdata <= {7'h00, hv_input_state};
                `POC_OFF_DRIVE: reg_rdata <= drive_full_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

/* File: sim/poc_properties.sv */
// checker: assertions on the port over-current and hv input block
`timescale 1ns/1ps
`default_nettype none
module poc_properties (
    input wire core_clk,
    input wire rst_n,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire stop_mode,
    input wire serial0_receive_line,
    input wire serial1_receive_line,
    input wire capture_in3,
    input wire [7:0] port_pin_out,
    input wire [7:0] port_pin_oe,
    input wire [7:0] port_full_drive,
    input wire [7:0] overcurrent_det,
    input wire [7:0] overcurrent_monitor_pwr,
    input wire hv_pullup_on,
    input wire hv_pulldown_on,
    input wire hv_analog_path_on,
    input wire hv_divider_bypass,
    input wire hv_buffer_on,
    input wire irq
);
    // ----------------------------------------
    // shadow registers and assertions
    // ----------------------------------------
    reg [1:0] route_reg;
    reg [7:0] ocen_reg;
    reg [7:0] mask_reg;
    reg [4:0] hv_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // shadow copies of the software control bits
    always @(posedge core_clk) begin
        if (!rst_n) begin
            route_reg <= 2'h0;
            ocen_reg <= 8'h00;
            mask_reg <= 8'h00;
            hv_reg <= 5'h00;
        end else if (reg_wr) begin
            route_reg <= (reg_addr == 4'h2) ? reg_wdata[1:0] : route_reg;
            ocen_reg <= (reg_addr == 4'h3) ? (reg_wdata & 8'h75) : ocen_reg;
            mask_reg <= (reg_addr == 4'h5) ? (reg_wdata & 8'h75) : mask_reg;
            hv_reg <= (reg_addr == 4'h6) ? reg_wdata[4:0] : hv_reg;
        end
    end
    route_sel_a: assert property (capture_in3 == (route_reg == 2'b10 ? serial1_receive_line : serial0_receive_line))
        else $error("capture input on wrong receive line");
    monitor_power_a: assert property (overcurrent_monitor_pwr == (ocen_reg & {8{!stop_mode}}))
        else $error("monitor power does not follow its enable");
    stop_drive_a: assert property (stop_mode |-> port_full_drive == 8'h00)
        else $error("full drive kept in stop");
    supply_trip_a: assert property ((overcurrent_det[2] && overcurrent_monitor_pwr[2] && port_full_drive[2]
        && port_pin_oe[2] && port_pin_out[2])[*3] |=> !port_pin_out[2])
        else $error("supply pin not forced low");
    ground_trip_a: assert property ((overcurrent_det[0] && overcurrent_monitor_pwr[0] && port_full_drive[0]
        && port_pin_oe[0] && !port_pin_out[0])[*3] |=> port_pin_out[0])
        else $error("ground pin not forced off");
    irq_mask_a: assert property (irq |-> mask_reg != 8'h00)
        else $error("interrupt with every source masked");
    pull_sel_a: assert property (hv_pullup_on == hv_reg[2] && hv_pulldown_on == !hv_reg[2])
        else $error("wrong hv pull device");
    analog_mode_a: assert property (hv_analog_path_on == (hv_reg[0] && !stop_mode) && hv_divider_bypass == (hv_reg[0] && hv_reg[1]))
        else $error("hv analog path setting wrong");
    buffer_force_a: assert property ((hv_reg[0] && !stop_mode) |-> hv_buffer_on == (hv_reg[3] && !hv_reg[1]))
        else $error("hv buffer wrong in analog mode");
    irq_seen_c: cover property (irq);
    trip_seen_c: cover property ($fell(port_pin_out[2]) && port_pin_oe[2]);
    force_seen_c: cover property (hv_reg[3] && hv_buffer_on);
endmodule
bind poc_top poc_properties u_chk (.*);
`default_nettype wire

/* File: sim/poc_load_model.sv */
// model of external loads and pull devices on the port pins
`timescale 1ns/1ps
`default_nettype none
module poc_load_model (
    input wire [7:0] short_en,
    input wire [1:0] ext_pull,
    input wire [7:0] pin_out,
    input wire [7:0] pin_oe,
    input wire [7:0] full_drive,
    input wire [7:0] monitor_pwr,
    input wire pullup_on,
    output wire [7:0] det,
    output wire hvi
);
    // a shorted load draws excess current only when sourced or sunk at full drive
    assign det = short_en & monitor_pwr & full_drive & pin_oe & (pin_out ~^ 8'h04);
    // external pull (1 down, 2 up) beats the weak internal one
    assign hvi = (ext_pull == 2'h1) ? 1'b0 : (ext_pull == 2'h2) ? 1'b1 : pullup_on;
endmodule
`default_nettype wire

/* File: sim/test_port_overcurrent_hvi_check.sv */
// testbench for the port over-current and hv input block
`timescale 1ns/1ps
`default_nettype none
module test_port_overcurrent_hvi_check;
    // ----------------------------------------
    // signals, tasks and main sequence
    // ----------------------------------------
    reg core_clk = 1'b0;
    reg rst_n = 1'b0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg stop_mode = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg [7:0] short_en = 8'h00;
    reg [1:0] ext_pull = 2'h0;
    wire [7:0] rdata, pin_out, pin_oe, full_drive, det, mon_pwr;
    wire cap, pu_on, pd_on, apath, bypass, buf_on, hvi, irq;
    integer failures = 0;
    integer checks_done = 0;
    integer i;
    poc_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .stop_mode(stop_mode),
        .serial0_receive_line(1'b1), .serial1_receive_line(1'b0), .capture_in3(cap),
        .port_pin_in(8'h00), .periph_out(8'h00), .periph_sel(8'h00), .port_pin_out(pin_out),
        .port_pin_oe(pin_oe), .port_full_drive(full_drive), .overcurrent_det(det),
        .overcurrent_monitor_pwr(mon_pwr), .high_voltage_input(hvi), .hv_pullup_on(pu_on),
        .hv_pulldown_on(pd_on), .hv_analog_path_on(apath), .hv_divider_bypass(bypass),
        .hv_buffer_on(buf_on), .irq(irq));
    poc_load_model i_load (.short_en(short_en), .ext_pull(ext_pull), .pin_out(pin_out), .pin_oe(pin_oe),
        .full_drive(full_drive), .monitor_pwr(mon_pwr), .pullup_on(pu_on), .det(det), .hvi(hvi));
    // clock and watchdog
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #200000;
        failures = failures + 1;
        give_verdict;
    end
    task check(input [7:0] seen, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge core_clk);
            #1;
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge core_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [7:0] e);
        begin
            @(posedge core_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1 check(rdata, e);
        end
    endtask
    // trip one protected pin, hold, mask, clear
    task oc_test(input integer p, input act);
        reg [7:0] m;
        begin
            m = 8'h01 << p;
            wr(4'h0, act ? m : 8'h00);
            wr(4'h1, m);
            wr(4'h8, m);
            wr(4'h3, 8'hFF);
            wr(4'h5, m);
            tick(1);
            check(mon_pwr, 8'h75);
            check(pin_oe, m);
            @(posedge core_clk) short_en <= m;
            tick(5);
            check({7'h00, pin_out[p]}, {7'h00, ~act});
            check({7'h00, irq}, 8'h01);
            rd(4'h4, m);
            @(posedge core_clk) short_en <= 8'h00;
            tick(5);
            check({7'h00, pin_out[p]}, {7'h00, ~act});
            wr(4'h5, 8'h00);
            tick(1);
            check({7'h00, irq}, 8'h00);
            wr(4'h4, m);
            tick(1);
            check({7'h00, pin_out[p]}, {7'h00, act});
            rd(4'h4, 8'h00);
        end
    endtask
    task hv_case(input [7:0] ctl, input [1:0] ep, input st, input bf);
        begin
            wr(4'h6, ctl);
            @(posedge core_clk) ext_pull <= ep;
            tick(4);
            check({7'h00, buf_on}, {7'h00, bf});
            check({4'h0, pu_on, pd_on, apath, bypass}, {4'h0, ctl[2], ~ctl[2], ctl[0], ctl[0] & ctl[1]});
            rd(4'h7, {7'h00, st});
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        tick(3);
        rst_n <= 1'b1;
        wr(4'hF, 8'hFF);
        for (i = 0; i < 9; i = i + 1) rd(i[3:0], 8'h00);
        rd(4'hF, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            wr(4'h2, i[7:0]);
            tick(1);
            check({7'h00, cap}, (i == 2) ? 8'h00 : 8'h01);
        end
        oc_test(2, 1'b1);
        oc_test(0, 1'b0);
        wr(4'h0, 8'h00);
        check(full_drive, 8'h01);
        @(posedge core_clk) stop_mode <= 1'b1;
        tick(1);
        check(full_drive, 8'h00);
        check(mon_pwr, 8'h00);
        @(posedge core_clk) stop_mode <= 1'b0;
        hv_case(8'h0D, 2'h1, 1'b0, 1'b1);
        hv_case(8'h0D, 2'h0, 1'b1, 1'b1);
        hv_case(8'h09, 2'h2, 1'b1, 1'b1);
        hv_case(8'h09, 2'h0, 1'b0, 1'b1);
        hv_case(8'h0B, 2'h2, 1'b0, 1'b0);
        hv_case(8'h01, 2'h2, 1'b0, 1'b0);
        give_verdict;
    end
endmodule
`default_nettype wire
